// ===== src/tcc_pkg.sv
// Purpose: Shared constants for the timer capture/compare register block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Byte address of a register is four times its index
package tcc_pkg;
  localparam int          ADDR_W       = 12;
  localparam int          IDX_W        = 10;
  localparam int          BYTE_W       = 8;
  localparam int          VAL_W        = 16;
  localparam int          DATA_W       = 32;
  localparam int          NUM_CAP      = 4;
  localparam int          NUM_OC       = 4;
  localparam int          SEL_W        = 2;

  // Register indices
  localparam logic [9:0]  IDX_T1_EDGE  = 10'h06A;
  localparam logic [9:0]  IDX_T1_AL    = 10'h06B;
  localparam logic [9:0]  IDX_T1_AH    = 10'h06C;
  localparam logic [9:0]  IDX_T1_BL    = 10'h06D;
  localparam logic [9:0]  IDX_T1_BH    = 10'h06E;
  localparam logic [9:0]  IDX_T3_EDGE  = 10'h07B;
  localparam logic [9:0]  IDX_T3_AL    = 10'h07C;
  localparam logic [9:0]  IDX_T3_AH    = 10'h07D;
  localparam logic [9:0]  IDX_T3_BL    = 10'h07E;
  localparam logic [9:0]  IDX_T3_BH    = 10'h07F;
  localparam logic [9:0]  IDX_OC_CTL   = 10'h080;
  localparam logic [9:0]  IDX_OC_ACT   = 10'h081;
  localparam logic [9:0]  IDX_IRQ_STAT = 10'h090;
  localparam logic [9:0]  IDX_IRQ_MASK = 10'h091;

  // Compare control fields
  localparam int          COMPARE_MODE_ENABLE_BIT    = 0;
  localparam int          FOLLOW_BIT   = 1;
  localparam int          INIT_LSB     = 2;
  localparam int          LANE0        = 0;
  localparam int          OC_IRQ_LSB   = 4;

  // Edge selector codes
  localparam logic [1:0]  EDGE_OFF     = 2'h0;
  localparam logic [1:0]  EDGE_FALL    = 2'h1;
  localparam logic [1:0]  EDGE_RISE    = 2'h2;
  localparam logic [1:0]  EDGE_BOTH    = 2'h3;

  // Compare action codes
  localparam logic [1:0]  ACT_INIT     = 2'h0;
  localparam logic [1:0]  ACT_CLEAR    = 2'h1;
  localparam logic [1:0]  ACT_SET      = 2'h2;
  localparam logic [1:0]  ACT_TOGGLE   = 2'h3;

  localparam logic [7:0]  BYTE_RESET   = 8'h00;
  localparam logic [3:0]  NIB_RESET    = 4'h0;
  localparam logic [15:0] VAL_RESET    = 16'h0000;
  localparam logic [31:0] WORD_RESET   = 32'h00000000;
  localparam logic [1:0]  ALIGNED      = 2'h0;
endpackage

// ===== src/tcc_capture_channel.sv
// Purpose: One capture input: synchroniser, edge select, value latch
// Assumes: count_value is on the clk domain; cap_pin is asynchronous
// Notes:   Capture pulse appears two edges after the pin settles
`timescale 1ns/1ns
`default_nettype none
module tcc_capture_channel (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        cap_pin,
  input  wire logic [1:0]  edge_select,
  input  wire logic [15:0] count_value,
  output var  logic [15:0] capture_value_q,
  output logic             capture_event
);
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic rise;
  logic fall;

  // Two-stage synchroniser and edge history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      sync1_q <= cap_pin;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // Edge qualification by selector
  assign rise = sync2_q & ~prev_q;
  assign fall = ~sync2_q & prev_q;
  always_comb begin
    case (edge_select)
      tcc_pkg::EDGE_FALL: capture_event = fall;
      tcc_pkg::EDGE_RISE: capture_event = rise;
      tcc_pkg::EDGE_BOTH: capture_event = rise | fall;
      default:            capture_event = 1'b0;
    endcase
  end

  // Whole 16-bit value taken in one clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_value_q <= tcc_pkg::VAL_RESET;
    end else if (capture_event) begin
      capture_value_q <= count_value;
    end
  end

  a_capture_loads: assert property (@(posedge clk) disable iff (!rst_n)
    capture_event |=> capture_value_q == $past(count_value))
    else $error("capture value not loaded from counter");

  a_sync_rise_delay: assert property (@(posedge clk) disable iff (!rst_n)
    ($rose(cap_pin) && edge_select == tcc_pkg::EDGE_RISE)
    ##1 (cap_pin && edge_select == tcc_pkg::EDGE_RISE) [*2]
    |-> capture_event)
    else $error("rising edge not captured two cycles later");

  a_single_capture: assert property (@(posedge clk) disable iff (!rst_n)
    capture_event |=> (!capture_event || sync2_q != $past(sync2_q)))
    else $error("one edge produced two captures");
endmodule
`default_nettype wire

// ===== src/tcc_regs.sv
// Purpose: Capture result registers and compare output control over APB
// Assumes: Counters and compare match pulses come from clk domain logic
// Notes:   Zero wait states; read data is registered in the setup cycle
`timescale 1ns/1ns
`default_nettype none
module tcc_regs (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output var  logic [31:0] prdata,
  output var  logic        pslverr,
  input  wire logic [15:0] timer1_count,
  input  wire logic [15:0] timer3_count,
  input  wire logic [3:0]  compare_match,
  input  wire logic        timer1_capture_input_zero,
  input  wire logic        timer1_capture_input_one,
  input  wire logic        timer3_capture_input_two,
  input  wire logic        timer3_capture_input_three,
  output logic             compare_output_zero,
  output logic             compare_output_one,
  output logic             compare_output_two,
  output logic             compare_output_three,
  output logic             irq
);
  logic [3:0]  t1_edge_q;
  logic [3:0]  t3_edge_q;
  logic [7:0]  oc_ctl_q;
  logic [7:0]  oc_act_q;
  logic [7:0]  irq_status_q;
  logic [7:0]  irq_mask_q;
  logic [7:0]  irq_set;
  logic [3:0]  oc_state_q;
  logic [3:0]  oc_state_d;
  logic [3:0]  oc_pin_q;
  logic [3:0]  cap_pin;
  logic [3:0]  cap_event;
  logic [7:0]  edge_all;
  logic [15:0] cap_value [0:3];
  logic [9:0]  idx;
  logic        aligned;
  logic        setup_ph;
  logic        access_ph;
  logic        wr_en;
  logic        status_rd;
  logic [31:0] rd_word;
  logic        rd_hit;

  // Capture pins in channel order
  assign cap_pin = {timer3_capture_input_three, timer3_capture_input_two,
                    timer1_capture_input_one, timer1_capture_input_zero};
  assign edge_all = {t3_edge_q, t1_edge_q};

  // Channels 0,1 on timer one, channels 2,3 on timer three
  genvar gi;
  generate
    for (gi = 0; gi < tcc_pkg::NUM_CAP; gi++) begin : g_cap
      tcc_capture_channel u_cap (
        .clk             (clk),
        .rst_n           (rst_n),
        .cap_pin         (cap_pin[gi]),
        .edge_select     (edge_all[gi*tcc_pkg::SEL_W +: tcc_pkg::SEL_W]),
        .count_value     ((gi < 2) ? timer1_count : timer3_count),
        .capture_value_q (cap_value[gi]),
        .capture_event   (cap_event[gi])
      );
    end
  endgenerate

  // APB decode; always ready
  assign idx       = paddr[11:2];
  assign aligned   = (paddr[1:0] == tcc_pkg::ALIGNED);
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign pready    = 1'b1;
  assign wr_en     = access_ph & pwrite & pstrb[tcc_pkg::LANE0] & aligned;
  assign status_rd = access_ph & ~pwrite & aligned
                   & (idx == tcc_pkg::IDX_IRQ_STAT);

  // Read multiplexer, narrow data in the low bits
  always_comb begin
    rd_word = tcc_pkg::WORD_RESET;
    rd_hit  = aligned;
    case (idx)
      tcc_pkg::IDX_T1_EDGE:  rd_word[3:0] = t1_edge_q;
      tcc_pkg::IDX_T1_AL:    rd_word[7:0] = cap_value[0][7:0];
      tcc_pkg::IDX_T1_AH:    rd_word[7:0] = cap_value[0][15:8];
      tcc_pkg::IDX_T1_BL:    rd_word[7:0] = cap_value[1][7:0];
      tcc_pkg::IDX_T1_BH:    rd_word[7:0] = cap_value[1][15:8];
      tcc_pkg::IDX_T3_EDGE:  rd_word[3:0] = t3_edge_q;
      tcc_pkg::IDX_T3_AL:    rd_word[7:0] = cap_value[2][7:0];
      tcc_pkg::IDX_T3_AH:    rd_word[7:0] = cap_value[2][15:8];
      tcc_pkg::IDX_T3_BL:    rd_word[7:0] = cap_value[3][7:0];
      tcc_pkg::IDX_T3_BH:    rd_word[7:0] = cap_value[3][15:8];
      tcc_pkg::IDX_OC_CTL:   rd_word[7:0] = oc_ctl_q;
      tcc_pkg::IDX_OC_ACT:   rd_word[7:0] = oc_act_q;
      tcc_pkg::IDX_IRQ_STAT: rd_word[7:0] = irq_status_q;
      tcc_pkg::IDX_IRQ_MASK: rd_word[7:0] = irq_mask_q;
      default:               rd_hit = 1'b0;
    endcase
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= tcc_pkg::WORD_RESET;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata  <= pwrite ? tcc_pkg::WORD_RESET : rd_word;
      pslverr <= ~rd_hit;
    end
  end

  // Writable registers; capture bytes ignore writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t1_edge_q  <= tcc_pkg::NIB_RESET;
      t3_edge_q  <= tcc_pkg::NIB_RESET;
      oc_ctl_q   <= tcc_pkg::BYTE_RESET;
      oc_act_q   <= tcc_pkg::BYTE_RESET;
      irq_mask_q <= tcc_pkg::BYTE_RESET;
    end else if (wr_en) begin
      case (idx)
        tcc_pkg::IDX_T1_EDGE:  t1_edge_q  <= pwdata[3:0];
        tcc_pkg::IDX_T3_EDGE:  t3_edge_q  <= pwdata[3:0];
        tcc_pkg::IDX_OC_CTL:   oc_ctl_q   <= pwdata[7:0];
        tcc_pkg::IDX_OC_ACT:   oc_act_q   <= pwdata[7:0];
        tcc_pkg::IDX_IRQ_MASK: irq_mask_q <= pwdata[7:0];
        default:               t1_edge_q  <= t1_edge_q;
      endcase
    end
  end

  // Sticky status; a read clears only the bits it returned, new events win
  assign irq_set = {compare_match
                    & {tcc_pkg::NUM_OC{oc_ctl_q[tcc_pkg::COMPARE_MODE_ENABLE_BIT]}},
                    cap_event};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_q <= tcc_pkg::BYTE_RESET;
    end else if (status_rd) begin
      irq_status_q <= (irq_status_q & ~prdata[tcc_pkg::BYTE_W-1:0]) | irq_set;
    end else begin
      irq_status_q <= irq_status_q | irq_set;
    end
  end
  assign irq = |(irq_status_q & irq_mask_q);

  // Per-output compare action
  genvar go;
  generate
    for (go = 0; go < tcc_pkg::NUM_OC; go++) begin : g_oc
      always_comb begin
        if (!oc_ctl_q[tcc_pkg::COMPARE_MODE_ENABLE_BIT]) begin
          oc_state_d[go] = oc_ctl_q[tcc_pkg::INIT_LSB + go];
        end else begin
          case (oc_act_q[go*tcc_pkg::SEL_W +: tcc_pkg::SEL_W])
            tcc_pkg::ACT_INIT:   oc_state_d[go] =
                                   oc_ctl_q[tcc_pkg::INIT_LSB + go];
            tcc_pkg::ACT_CLEAR:  oc_state_d[go] =
                                   oc_state_q[go] & ~compare_match[go];
            tcc_pkg::ACT_SET:    oc_state_d[go] =
                                   oc_state_q[go] | compare_match[go];
            tcc_pkg::ACT_TOGGLE: oc_state_d[go] =
                                   oc_state_q[go] ^ compare_match[go];
            default:             oc_state_d[go] = oc_state_q[go];
          endcase
        end
      end
    end
  endgenerate

  // Output state and pins; follow mode copies output zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_state_q <= tcc_pkg::NIB_RESET;
      oc_pin_q   <= tcc_pkg::NIB_RESET;
    end else begin
      oc_state_q <= oc_state_d;
      oc_pin_q   <= oc_ctl_q[tcc_pkg::FOLLOW_BIT]
                  ? {tcc_pkg::NUM_OC{oc_state_d[0]}} : oc_state_d;
    end
  end
  assign compare_output_zero  = oc_pin_q[0];
  assign compare_output_one   = oc_pin_q[1];
  assign compare_output_two   = oc_pin_q[2];
  assign compare_output_three = oc_pin_q[3];

  a_low_byte_map: assert property (@(posedge clk) disable iff (!rst_n)
    (setup_ph && !pwrite && aligned && idx == tcc_pkg::IDX_T1_AL)
    |=> prdata == {24'h000000, $past(cap_value[0][7:0])})
    else $error("first low byte read wrong");

  a_high_byte_map: assert property (@(posedge clk) disable iff (!rst_n)
    (setup_ph && !pwrite && aligned && idx == tcc_pkg::IDX_T3_AH)
    |=> prdata == {24'h000000, $past(cap_value[2][15:8])})
    else $error("timer three first high byte read wrong");

  a_second_pair_map: assert property (@(posedge clk) disable iff (!rst_n)
    (setup_ph && !pwrite && aligned && idx == tcc_pkg::IDX_T3_BL)
    |=> prdata == {24'h000000, $past(cap_value[3][7:0])})
    else $error("timer three second low byte read wrong");

  a_ctrl_write: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_en && idx == tcc_pkg::IDX_OC_CTL)
    |=> oc_ctl_q == $past(pwdata[7:0]))
    else $error("compare control write lost");

  a_disabled_init: assert property (@(posedge clk) disable iff (!rst_n)
    !oc_ctl_q[tcc_pkg::COMPARE_MODE_ENABLE_BIT]
    |=> oc_state_q == $past(oc_ctl_q[5:2]))
    else $error("disabled output not at init level");

  a_follow_zero: assert property (@(posedge clk) disable iff (!rst_n)
    oc_ctl_q[tcc_pkg::FOLLOW_BIT]
    |=> oc_pin_q == {4{oc_state_q[0]}})
    else $error("outputs do not copy output zero");

  a_toggle_match: assert property (@(posedge clk) disable iff (!rst_n)
    (oc_ctl_q[tcc_pkg::COMPARE_MODE_ENABLE_BIT] && oc_act_q[1:0] == tcc_pkg::ACT_TOGGLE
     && compare_match[0])
    |=> oc_state_q[0] != $past(oc_state_q[0]))
    else $error("toggle on match missing");

  a_set_beats_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (status_rd && cap_event[0]) |=> irq_status_q[0])
    else $error("capture event lost during status clear");

  a_ro_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_en && idx == tcc_pkg::IDX_T3_BL && !cap_event[3])
    |=> $stable(cap_value[3]))
    else $error("capture byte changed by a write");

  a_t1_first_high: assert property (@(posedge clk) disable iff (!rst_n)
    (setup_ph && !pwrite && aligned && idx == tcc_pkg::IDX_T1_AH)
    |=> prdata == {24'h000000, $past(cap_value[0][15:8])})
    else $error("timer one first high byte read wrong");

  a_t1_second_high: assert property (@(posedge clk) disable iff (!rst_n)
    (setup_ph && !pwrite && aligned && idx == tcc_pkg::IDX_T1_BH)
    |=> prdata == {24'h000000, $past(cap_value[1][15:8])})
    else $error("timer one second high byte read wrong");

  a_t1_pair_source: assert property (@(posedge clk) disable iff (!rst_n)
    cap_event[0] |=> cap_value[0] == $past(timer1_count))
    else $error("timer one first pair not from timer one");

  a_t3_pair_source: assert property (@(posedge clk) disable iff (!rst_n)
    cap_event[3] |=> cap_value[3] == $past(timer3_count))
    else $error("timer three second pair not from timer three");

  a_ro_no_error: assert property (@(posedge clk) disable iff (!rst_n)
    (setup_ph && pwrite && aligned && idx == tcc_pkg::IDX_T3_BL)
    |=> !pslverr)
    else $error("write to capture byte flagged as error");

  a_clear_match: assert property (@(posedge clk) disable iff (!rst_n)
    (oc_ctl_q[tcc_pkg::COMPARE_MODE_ENABLE_BIT] && oc_act_q[3:2] == tcc_pkg::ACT_CLEAR
     && compare_match[1])
    |=> !oc_state_q[1])
    else $error("clear on match missing");

  a_set_match: assert property (@(posedge clk) disable iff (!rst_n)
    (oc_ctl_q[tcc_pkg::COMPARE_MODE_ENABLE_BIT] && oc_act_q[5:4] == tcc_pkg::ACT_SET
     && compare_match[2])
    |=> oc_state_q[2])
    else $error("set on match missing");

  a_pins_independent: assert property (@(posedge clk) disable iff (!rst_n)
    !oc_ctl_q[tcc_pkg::FOLLOW_BIT]
    |=> oc_pin_q == oc_state_q)
    else $error("independent outputs not at own state");

  a_status_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    !status_rd
    |=> (irq_status_q & $past(irq_status_q)) == $past(irq_status_q))
    else $error("status bit dropped without a read");

  a_status_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (status_rd && irq_set == tcc_pkg::BYTE_RESET)
    |=> (irq_status_q & $past(prdata[7:0])) == tcc_pkg::BYTE_RESET)
    else $error("status bits read but not cleared");

  a_match_gated: assert property (@(posedge clk) disable iff (!rst_n)
    (!oc_ctl_q[tcc_pkg::COMPARE_MODE_ENABLE_BIT] && !status_rd)
    |=> irq_status_q[7:4] == $past(irq_status_q[7:4]))
    else $error("match status set while compare disabled");
endmodule
`default_nettype wire

// ===== bench/tcc_pin_model.sv
// Purpose: Far-side model of the four asynchronous capture pins
// Assumes: Pins change right after a rising clock edge
// Notes:   Each level is held at least four cycles before it may change
`timescale 1ns/1ns
`default_nettype none
module tcc_pin_model (
  input  wire logic       clk,
  output var  logic [3:0] cap_pins
);
  // Pins idle low from time zero
  initial begin
    cap_pins = 4'h0;
  end

  // Flip one pin, then hold it long enough for the synchroniser
  task automatic flip(input int ch);
    @(posedge clk);
    cap_pins[ch] <= ~cap_pins[ch];
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== bench/tb.sv
// Purpose: Self-checking bench for the capture/compare register block
// Assumes: Zero-wait APB slave, capture seen two edges after a pin edge
// Notes:   Expected values come from a small model held in this module
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin \
  checks++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("Error %s expected %h seen %h", nm, e, g); \
  end \
end
module tb;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic        oc0, oc1, oc2, oc3, mst;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb, cm, pins, ini, st_m;
  logic [15:0] t1c, t3c;
  logic [15:0] cap_m [4];
  logic [7:0]  stat_m, mask_m, act;
  logic [9:0]  lo [4] = '{tcc_pkg::IDX_T1_AL, tcc_pkg::IDX_T1_BL,
                          tcc_pkg::IDX_T3_AL, tcc_pkg::IDX_T3_BL};
  int          failures, checks;

  tcc_regs u_tcc_regs (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .timer1_count(t1c), .timer3_count(t3c), .compare_match(cm),
    .timer1_capture_input_zero(pins[0]), .timer1_capture_input_one(pins[1]),
    .timer3_capture_input_two(pins[2]), .timer3_capture_input_three(pins[3]),
    .compare_output_zero(oc0), .compare_output_one(oc1),
    .compare_output_two(oc2), .compare_output_three(oc3), .irq(irq));
  tcc_pin_model u_tcc_pin_model (.clk(clk), .cap_pins(pins));

  // 100 MHz clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Print counts and verdict, then end the run
  task automatic report_and_stop();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic [11:0] a, input logic wr,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb({i, 2'h0}, 1'h1, d, r, e);
    `CHK("write err", 1'h0, e)
  endtask

  task automatic rd(input logic [9:0] i, input string nm,
                    input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb({i, 2'h0}, 1'h0, 32'h0, r, e);
    `CHK(nm, x, r)
    `CHK("read err", 1'h0, e)
  endtask

  // Match pulse of one cycle; with en set, model steps each matched output
  task automatic pulse(input logic [3:0] m, input logic en);
    @(posedge clk);
    cm <= m;
    @(posedge clk);
    cm <= 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (en && m[i]) begin
        case (act[2*i +: 2])
          2'h0: st_m[i] = ini[i];
          2'h1: st_m[i] = 1'h0;
          2'h2: st_m[i] = 1'h1;
          default: st_m[i] = ~st_m[i];
        endcase
        stat_m[4+i] = 1'h1;
      end
    end
    @(negedge clk);
    `CHK("pins", mst ? {4{st_m[0]}} : st_m, {oc3, oc2, oc1, oc0})
  endtask

  // Hang guard
  initial begin
    #500000;
    failures++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    logic [31:0] r;
    logic        e, rise;
    logic [15:0] c1, c3;
    void'($urandom(53749));
    {rst_n, psel, penable, pwrite, paddr, pwdata, cm} = '0;
    {t1c, t3c, stat_m} = '0;
    pstrb = 4'hF;
    failures = 0;
    checks = 0;
    for (int i = 0; i < 4; i++) cap_m[i] = 16'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    `CHK("reset outs", 5'h00, {oc3, oc2, oc1, oc0, irq})
    `CHK("pready", 1'h1, pready)
    for (int i = 0; i < 4; i++) begin
      rd(lo[i], "cap low reset", 32'h0);
      rd(lo[i] + 10'h1, "cap high reset", 32'h0);
    end
    rd(tcc_pkg::IDX_OC_CTL, "ctl reset", 32'h0);
    wr(lo[3], 32'hFF);
    rd(lo[3], "cap read only", 32'h0);
    apb(12'hFFC, 1'h0, 32'h0, r, e);
    `CHK("unmapped", 1'h1, e)
    apb(12'h201, 1'h0, 32'h0, r, e);
    `CHK("unaligned", 1'h1, e)
    // Every edge code on every pin, both directions
    for (int c = 0; c < 4; c++) begin
      mask_m = 8'($urandom());
      wr(tcc_pkg::IDX_IRQ_MASK, {24'h0, mask_m});
      wr(tcc_pkg::IDX_T1_EDGE, 32'(c * 5));
      wr(tcc_pkg::IDX_T3_EDGE, 32'(c * 5));
      for (int ch = 0; ch < 4; ch++) begin
        for (int k = 0; k < 2; k++) begin
          c1 = 16'($urandom());
          c3 = 16'($urandom());
          t1c <= c1;
          t3c <= c3;
          u_tcc_pin_model.flip(ch);
          rise = u_tcc_pin_model.cap_pins[ch];
          if (c == 3 || (c == 2 && rise) || (c == 1 && !rise)) begin
            cap_m[ch] = (ch < 2) ? c1 : c3;
            stat_m[ch] = 1'h1;
          end
          t1c <= ~c1;
          t3c <= ~c3;
          repeat (4) @(posedge clk);
          rd(lo[ch], "cap low", {24'h0, cap_m[ch][7:0]});
          rd(lo[ch] + 10'h1, "cap high", {24'h0, cap_m[ch][15:8]});
        end
      end
      `CHK("irq", |(stat_m & mask_m), irq)
      rd(tcc_pkg::IDX_IRQ_STAT, "cap status", {24'h0, stat_m});
      stat_m = 8'h0;
      @(negedge clk);
      `CHK("irq clear", 1'h0, irq)
    end
    // Compare outputs: init levels, master mode, all actions
    mask_m = 8'hFF;
    wr(tcc_pkg::IDX_IRQ_MASK, 32'hFF);
    for (int it = 0; it < 8; it++) begin
      ini = 4'($urandom());
      act = 8'($urandom());
      mst = 1'($urandom());
      wr(tcc_pkg::IDX_OC_ACT, {24'h0, act});
      wr(tcc_pkg::IDX_OC_CTL, {26'h0, ini, mst, 1'h0});
      st_m = ini;
      pulse(4'($urandom()), 1'h0);
      rd(tcc_pkg::IDX_OC_CTL, "ctl", {26'h0, ini, mst, 1'h0});
      wr(tcc_pkg::IDX_OC_CTL, {26'h0, ini, mst, 1'h1});
      repeat (4) pulse(4'($urandom()), 1'h1);
      `CHK("irq match", |stat_m, irq)
      rd(tcc_pkg::IDX_IRQ_STAT, "match status", {24'h0, stat_m});
      stat_m = 8'h0;
    end
    // Byte lane zero off: the control write must not land
    pstrb <= 4'hE;
    wr(tcc_pkg::IDX_OC_CTL, 32'h3C);
    pstrb <= 4'hF;
    rd(tcc_pkg::IDX_OC_CTL, "strobe off", {26'h0, ini, mst, 1'h1});
    // Reset in mid-run clears captures, control and outputs
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    `CHK("reset again", 5'h00, {oc3, oc2, oc1, oc0, irq})
    for (int i = 0; i < 4; i++) begin
      rd(lo[i], "cap low after reset", 32'h0);
      rd(lo[i] + 10'h1, "cap high after reset", 32'h0);
    end
    rd(tcc_pkg::IDX_OC_CTL, "ctl after reset", 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
